// ===== lhp_pkg.sv
package lhp_pkg;
  // Command opcodes
  localparam logic [7:0] CMD_GLYPH_BASE_SET  = 8'h5c;
  localparam logic [7:0] CMD_CURSOR_DIR      = 8'h4c;
  localparam logic [7:0] CMD_CURSOR_LOAD     = 8'h46;
  localparam logic [7:0] CMD_MEMORY_WRITE    = 8'h42;
  localparam logic [7:0] CMD_MEMORY_READ     = 8'h43;
  localparam logic [7:0] CMD_SYSTEM_SET      = 8'h40;
  localparam logic [7:0] CMD_SLEEP_IN        = 8'h53;
  // Glyph address layout
  localparam int         SHORT_CODE_LSB      = 3;
  localparam int         TALL_CODE_LSB       = 4;
  localparam int         FOLD_BIT            = 6;
  // Code ranges kept for RAM glyphs while the internal ROM is in use
  localparam logic [7:0] RAM_LOW_FIRST       = 8'h80;
  localparam logic [7:0] RAM_LOW_LAST        = 8'h9f;
  localparam logic [7:0] RAM_HIGH_FIRST      = 8'he0;
  // Memory bus runs at a third of the clock
  localparam logic [1:0] MEM_DIV_LAST        = 2'h2;
  // Reset values
  localparam logic [15:0] CURSOR_RESET       = 16'h0000;
  localparam logic [15:0] BASE_RESET         = 16'h0000;
  localparam logic [7:0]  LINE_TOTAL_RESET   = 8'h22;
  localparam logic [7:0]  LINE_SHOWN_RESET   = 8'h1f;

  typedef enum logic [1:0]
  {
    ACC_NONE,
    ACC_STATUS_RD,
    ACC_DATA_RD,
    ACC_DATA_WR
  } lhp_acc_t;

  // One decoded host cycle
  typedef struct packed
  {
    logic       cmd_wr;
    logic       data_wr;
    logic       data_rd;
    logic       status_rd;
  } lhp_host_op_t;

  // Display memory request
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } lhp_mem_req_t;
endpackage : lhp_pkg

// ===== lhp_host_port.sv
`timescale 1ns/1ps
module lhp_host_port
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 16
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Host pins
  input  wire logic              cs_n,
  input  wire logic              command_data_select,
  input  wire logic              rd_pin,
  input  wire logic              wr_pin,
  input  wire logic              bus_style_select_a,
  input  wire logic              bus_style_select_b,
  input  wire logic [DATA_W-1:0] host_d_in,
  output logic      [DATA_W-1:0] host_d_out,
  output logic                   host_d_oe,
  // Glyph configuration
  input  wire logic              internal_rom_en,
  input  wire logic              glyph_bit6_fold,
  input  wire logic              tall_glyph_select,
  input  wire logic [7:0]        total_line_bytes,
  input  wire logic [7:0]        shown_line_bytes,
  // Glyph lookup
  input  wire logic [7:0]        glyph_code,
  input  wire logic [3:0]        glyph_row,
  output logic      [ADDR_W-1:0] glyph_addr,
  output logic                   glyph_from_ram,
  // Display memory
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_wdata,
  output logic                   mem_we,
  output logic                   mem_re,
  input  wire logic [DATA_W-1:0] mem_rdata,
  // State
  output logic                   sleep_mode,
  output logic                   retrace_status_bit
);

  default clocking cb_ast @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Three-stage pin synchronisers; first stage is read only by the second
  localparam int NSYNC = 6 + DATA_W;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] pin_reg;
  logic [NSYNC-1:0] raw;
  assign raw = {bus_style_select_a, bus_style_select_b, cs_n,
                command_data_select, rd_pin, wr_pin, host_d_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          s1_reg[gi]  <= 1'b1;
          s2_reg[gi]  <= 1'b1;
          s3_reg[gi]  <= 1'b1;
          pin_reg[gi] <= 1'b1;
        end
        else
        begin
          s1_reg[gi] <= raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
            pin_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  logic              p_sel_a;
  logic              p_sel_b;
  logic              p_cs_n;
  logic              p_a0;
  logic              p_rd;
  logic              p_wr;
  logic [DATA_W-1:0] p_d;
  assign {p_sel_a, p_sel_b, p_cs_n, p_a0, p_rd, p_wr, p_d} = pin_reg;

  // Style follows the filtered select pins on every cycle after reset
  logic style_reg;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      style_reg <= 1'b0;
    else
      style_reg <= p_sel_a & ~p_sel_b;
  end

  function automatic lhp_pkg::lhp_acc_t decode_acc
  (
    input logic style,
    input logic a0,
    input logic rd,
    input logic wr
  );
    lhp_pkg::lhp_acc_t acc;
    acc = lhp_pkg::ACC_NONE;
    if (!style)
    begin
      if (!rd && wr)
        acc = a0 ? lhp_pkg::ACC_DATA_RD : lhp_pkg::ACC_STATUS_RD;
    end
    else if (wr && rd)
      acc = a0 ? lhp_pkg::ACC_DATA_RD : lhp_pkg::ACC_STATUS_RD;
    return acc;
  endfunction : decode_acc

  // Write active level per style: in style 1 rd_pin is direction, wr_pin enable; in style 0 both are low-active strobes
  logic wr_act;
  assign wr_act = style_reg ? (p_wr & ~p_rd) : (~p_wr & p_rd);
  logic wr_act_q;
  logic rd_act_q;
  lhp_pkg::lhp_acc_t acc;
  assign acc = p_cs_n ? lhp_pkg::ACC_NONE
                      : decode_acc(style_reg, p_a0, p_rd, p_wr);

  lhp_pkg::lhp_host_op_t op;
  always_comb
  begin
    op.cmd_wr    = ~p_cs_n & wr_act & ~wr_act_q & p_a0;
    op.data_wr   = ~p_cs_n & wr_act & ~wr_act_q & ~p_a0;
    op.data_rd   = (acc == lhp_pkg::ACC_DATA_RD) & ~rd_act_q;
    op.status_rd = (acc == lhp_pkg::ACC_STATUS_RD);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end
    else
    begin
      wr_act_q <= ~p_cs_n & wr_act;
      rd_act_q <= acc == lhp_pkg::ACC_DATA_RD;
    end
  end

  // Command and parameter capture
  logic [7:0]        cmd_reg;
  logic [1:0]        pidx_reg;
  logic [ADDR_W-1:0] cursor_reg;
  logic [ADDR_W-1:0] glyph_base_address;
  logic              cur_inc_reg;
  logic              cmd_ok;
  assign cmd_ok = !sleep_mode
               || p_d == lhp_pkg::CMD_SYSTEM_SET
               || p_d == lhp_pkg::CMD_SLEEP_IN;

  // Memory pipeline: one-entry write/read request, served on div tick
  logic [1:0]  div_reg;
  logic        tick;
  assign tick = div_reg == lhp_pkg::MEM_DIV_LAST;
  logic        wpend_reg;
  logic [7:0]  wbuf_reg;
  logic        rpend_reg;
  logic [7:0]  rbuf_reg;
  logic        cur_step;
  assign cur_step = tick & (wpend_reg | rpend_reg);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      div_reg <= 2'h0;
    else
      div_reg <= tick ? 2'h0 : div_reg + 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cmd_reg            <= 8'h00;
      pidx_reg           <= 2'h0;
      glyph_base_address <= lhp_pkg::BASE_RESET;
      cur_inc_reg        <= 1'b0;
      sleep_mode         <= 1'b0;
    end
    else if (op.cmd_wr && cmd_ok)
    begin
      cmd_reg  <= p_d;
      pidx_reg <= 2'h0;
      if (p_d == lhp_pkg::CMD_CURSOR_DIR)
        cur_inc_reg <= 1'b1;
      if (p_d == lhp_pkg::CMD_SLEEP_IN)
        sleep_mode <= 1'b1;
      else if (p_d == lhp_pkg::CMD_SYSTEM_SET)
        sleep_mode <= 1'b0;
    end
    else if (op.data_wr && !sleep_mode)
    begin
      if (pidx_reg != 2'h3)
        pidx_reg <= pidx_reg + 2'h1;
      if (cmd_reg == lhp_pkg::CMD_GLYPH_BASE_SET)
      begin
        if (pidx_reg == 2'h0)
          glyph_base_address[7:0] <= p_d;
        else if (pidx_reg == 2'h1)
          glyph_base_address[15:8] <= p_d;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cursor_reg <= lhp_pkg::CURSOR_RESET;
    else if (op.data_wr && !sleep_mode
             && cmd_reg == lhp_pkg::CMD_CURSOR_LOAD && pidx_reg == 2'h0)
      cursor_reg[7:0] <= p_d;
    else if (op.data_wr && !sleep_mode
             && cmd_reg == lhp_pkg::CMD_CURSOR_LOAD && pidx_reg == 2'h1)
      cursor_reg[15:8] <= p_d;
    else if (cur_step && cur_inc_reg)
      cursor_reg <= cursor_reg + 16'h0001;
  end

  // Write buffer and read-ahead buffer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wpend_reg <= 1'b0;
      wbuf_reg  <= 8'h00;
      rpend_reg <= 1'b0;
      rbuf_reg  <= 8'h00;
    end
    else
    begin
      if (op.data_wr && !sleep_mode
          && cmd_reg == lhp_pkg::CMD_MEMORY_WRITE)
      begin
        wpend_reg <= 1'b1;
        wbuf_reg  <= p_d;
      end
      else if (tick)
        wpend_reg <= 1'b0;
      if ((op.cmd_wr && cmd_ok && p_d == lhp_pkg::CMD_MEMORY_READ)
          || (op.data_rd && cmd_reg == lhp_pkg::CMD_MEMORY_READ))
        rpend_reg <= 1'b1;
      else if (tick && !wpend_reg)
        rpend_reg <= 1'b0;
      if (mem_re)
        rbuf_reg <= mem_rdata;
    end
  end

  // Memory port registered; one access per third cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mem_addr  <= '0;
      mem_wdata <= '0;
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
    end
    else
    begin
      mem_we <= tick & wpend_reg;
      mem_re <= tick & ~wpend_reg & rpend_reg;
      if (tick)
      begin
        mem_addr  <= cursor_reg;
        mem_wdata <= wbuf_reg;
      end
    end
  end

  // Retrace status: count line bytes, high past the shown part
  logic [7:0] byte_cnt_reg;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      byte_cnt_reg <= 8'h00;
    else if (tick)
      byte_cnt_reg <= (byte_cnt_reg >= total_line_bytes)
                      ? 8'h00 : byte_cnt_reg + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      retrace_status_bit <= 1'b0;
    else
      retrace_status_bit <= byte_cnt_reg > shown_line_bytes;
  end

  // Host read data
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      host_d_out <= '0;
      host_d_oe  <= 1'b0;
    end
    else
    begin
      host_d_oe <= acc != lhp_pkg::ACC_NONE;
      if (acc == lhp_pkg::ACC_STATUS_RD)
        host_d_out <= {1'b0, retrace_status_bit, 6'h00};
      // Latched at read start; the next fetch must not change it
      else if (op.data_rd && cmd_reg == lhp_pkg::CMD_MEMORY_READ)
        host_d_out <= rbuf_reg;
      else if (op.data_rd)
        host_d_out <= p_a0 ? cursor_reg[7:0] : cursor_reg[15:8];
    end
  end

  // Glyph address formation
  logic [7:0] code_f;
  logic       ram_code;
  always_comb
  begin
    code_f = glyph_code;
    ram_code = !internal_rom_en
      || (glyph_code >= lhp_pkg::RAM_LOW_FIRST
          && glyph_code <= lhp_pkg::RAM_LOW_LAST)
      || glyph_code >= lhp_pkg::RAM_HIGH_FIRST;
    if (glyph_bit6_fold)
      code_f[lhp_pkg::FOLD_BIT] = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      glyph_addr     <= '0;
      glyph_from_ram <= 1'b0;
    end
    else
    begin
      glyph_from_ram <= ram_code;
      if (tall_glyph_select)
        glyph_addr <= glyph_base_address
          + {4'h0, code_f, 4'h0} + {12'h000, glyph_row};
      else
        glyph_addr <= glyph_base_address
          + {5'h00, code_f, 3'h0} + {13'h0000, glyph_row[2:0]};
    end
  end

  // Assertions
  sequence s_we_quiet;
    !mem_we ##1 !mem_we;
  endsequence

  AST_MEM_THIRD: assert property (
    mem_we |=> s_we_quiet)
    else $error("mem strobe too fast");
  AST_BASE_LOW: assert property (
    (op.data_wr && !sleep_mode && cmd_reg == lhp_pkg::CMD_GLYPH_BASE_SET
     && pidx_reg == 2'h0) |=> glyph_base_address[7:0] == $past(p_d))
    else $error("base low byte lost");
  AST_CUR_LOAD: assert property (
    (op.data_wr && !sleep_mode && cmd_reg == lhp_pkg::CMD_CURSOR_LOAD
     && pidx_reg == 2'h1) |=> cursor_reg[15:8] == $past(p_d))
    else $error("cursor high byte lost");
  AST_CUR_STEP: assert property (
    (cur_step && cur_inc_reg && !op.data_wr)
    |=> cursor_reg == $past(cursor_reg) + 16'h0001)
    else $error("cursor did not step");
  AST_WR_BUF: assert property (
    (op.data_wr && !sleep_mode && cmd_reg == lhp_pkg::CMD_MEMORY_WRITE)
    |=> ##[0:3] mem_we)
    else $error("buffered write not issued");
  AST_SLEEP: assert property (
    (sleep_mode && op.cmd_wr && p_d != lhp_pkg::CMD_SYSTEM_SET
     && p_d != lhp_pkg::CMD_SLEEP_IN) |=> cmd_reg == $past(cmd_reg))
    else $error("command taken in sleep");
  AST_STATUS: assert property (
    (byte_cnt_reg <= shown_line_bytes) |=> !retrace_status_bit)
    else $error("status high while fetching");
  AST_TALL: assert property (
    tall_glyph_select |=> glyph_addr == $past(glyph_base_address)
      + {4'h0, $past(code_f), 4'h0} + {12'h000, $past(glyph_row)})
    else $error("tall glyph address wrong");
  AST_FOLD: assert property (
    (glyph_bit6_fold && !tall_glyph_select) |=> glyph_addr ==
      $past(glyph_base_address)
      + {5'h00, $past(glyph_code) & 8'hbf, 3'h0}
      + {13'h0000, $past(glyph_row[2:0])})
    else $error("bit 6 not folded");
  AST_RD_HOLD: assert property (
    (acc == lhp_pkg::ACC_DATA_RD && rd_act_q) |=> $stable(host_d_out))
    else $error("read data changed mid read");

endmodule : lhp_host_port

// ===== lhp_host_model.sv
`timescale 1ns/1ps
module lhp_host_model
(
  // Clock and strobe style
  input  wire logic       sys_clk,
  input  wire logic       style_e,
  // Host pins
  output logic            cs_n,
  output logic            a0,
  output logic            rd_pin,
  output logic            wr_pin,
  output logic [7:0]      bus,
  // Device side of the data bus
  input  wire logic [7:0] dev_d,
  input  wire logic       dev_oe
);
  // Strobe and gap well above the pin filter, far above the device cycle
  localparam int HOLD = 10;
  logic [7:0] drv;
  logic       drv_en;
  logic [7:0] last;

  // A released bus shows the inverse of its last level
  assign bus = drv_en ? drv : (dev_oe ? dev_d : ~last);

  always @(posedge sys_clk)
    last <= bus;

  initial
  begin
    drv    = 8'h00;
    last   = 8'h00;
    drv_en = 1'b0;
    cs_n   = 1'b1;
    a0     = 1'b0;
    rd_pin = 1'b1;
    wr_pin = 1'b1;
  end

  task automatic idle();
    cs_n   <= 1'b1;
    rd_pin <= ~style_e;
    wr_pin <= ~style_e;
    drv_en <= 1'b0;
  endtask : idle

  // No busy polling: every access is a fixed-length bus cycle
  task automatic access(input logic sel, input logic rd,
                        input logic [7:0] wd, output logic [7:0] q);
    @(posedge sys_clk);
    cs_n   <= 1'b0;
    a0     <= sel;
    drv    <= wd;
    drv_en <= ~rd;
    rd_pin <= style_e ? rd : ~rd;
    wr_pin <= style_e ? 1'b1 : rd;
    repeat (HOLD) @(posedge sys_clk);
    q = bus;
    idle();
    repeat (HOLD) @(posedge sys_clk);
  endtask : access

  function automatic logic [15:0] load_addr(input logic [15:0] base,
    input logic [7:0] code, input logic tall, input logic fold,
    input logic [3:0] row);
    logic [7:0] c;
    c = code;
    if (fold)
      c[6] = 1'b0;
    if (tall)
      return base + {4'h0, c, 4'h0} + {12'h0, row};
    return base + {5'h0, c, 3'h0} + {13'h0, row[2:0]};
  endfunction : load_addr
endmodule : lhp_host_model

// ===== lcd_ctrl_host_port_cg_addressing_test.sv
`timescale 1ns/1ps
module lcd_ctrl_host_port_cg_addressing_test;
  localparam int LIMIT = 20000;
  logic        sys_clk;
  logic        rst_n;
  logic        style_e;
  logic        style_b;
  logic        cs_n;
  logic        a0;
  logic        rd_pin;
  logic        wr_pin;
  logic [7:0]  bus;
  logic [7:0]  d_out;
  logic        d_oe;
  logic        rom_en;
  logic        fold;
  logic        tall;
  logic [7:0]  code;
  logic [3:0]  row;
  logic [15:0] g_addr;
  logic        g_ram;
  logic [15:0] m_addr;
  logic [7:0]  m_wdata;
  logic        m_we;
  logic        m_re;
  logic [7:0]  m_rdata;
  logic        slp;
  logic        retr;
  logic [7:0]  mem [0:65535];
  int          n_errors;
  int          num_checks;
  int          cyc;
  int          wcnt;
  int          last_we;

  lhp_host_model host
  (
    .sys_clk (sys_clk), .style_e (style_e & ~style_b),
    .cs_n (cs_n), .a0 (a0),
    .rd_pin (rd_pin), .wr_pin (wr_pin), .bus (bus), .dev_d (d_out),
    .dev_oe (d_oe)
  );

  lhp_host_port dut
  (
    .sys_clk (sys_clk), .rst_n (rst_n), .cs_n (cs_n),
    .command_data_select (a0), .rd_pin (rd_pin), .wr_pin (wr_pin),
    .bus_style_select_a (style_e), .bus_style_select_b (style_b),
    .host_d_in (bus), .host_d_out (d_out), .host_d_oe (d_oe),
    .internal_rom_en (rom_en), .glyph_bit6_fold (fold),
    .tall_glyph_select (tall), .total_line_bytes (8'h22),
    .shown_line_bytes (8'h1f), .glyph_code (code), .glyph_row (row),
    .glyph_addr (g_addr), .glyph_from_ram (g_ram), .mem_addr (m_addr),
    .mem_wdata (m_wdata), .mem_we (m_we), .mem_re (m_re),
    .mem_rdata (m_rdata), .sleep_mode (slp), .retrace_status_bit (retr)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever
      #5 sys_clk = ~sys_clk;
  end

  // Display memory; idle read lines carry a moving pattern
  assign m_rdata = m_re ? mem[m_addr] : ~m_addr[7:0];

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc >= LIMIT)
    begin
      n_errors++;
      complete_run();
    end
    if (m_we === 1'b1)
    begin
      mem[m_addr] <= m_wdata;
      if (wcnt > 0)
        chk(16'((cyc - last_we) % 3), 16'h0);
      wcnt++;
      last_we = cyc;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic sel, input logic [7:0] d);
    logic [7:0] x;
    host.access(sel, 1'b0, d, x);
  endtask : wr

  task automatic t_glyph();
    logic [14:0] tab [7];
    logic        r;
    tab = '{15'h7_80f, 15'h4_9f7, 15'h7_e03, 15'h6_ff0, 15'h4_412,
            15'h1_419, 15'h4_a01};
    wr(1'b1, lhp_pkg::CMD_GLYPH_BASE_SET);
    wr(1'b0, 8'h00);
    wr(1'b0, 8'h40);
    foreach (tab[i])
    begin
      @(posedge sys_clk);
      {rom_en, fold, tall, code, row} <= tab[i];
      repeat (3) @(posedge sys_clk);
      r = !rom_en || code >= lhp_pkg::RAM_HIGH_FIRST ||
          (code >= lhp_pkg::RAM_LOW_FIRST && code <= lhp_pkg::RAM_LOW_LAST);
      chk(g_addr, host.load_addr(16'h4000, code, tall, fold, row));
      chk({15'h0, g_ram}, {15'h0, r});
    end
  endtask : t_glyph

  task automatic t_write(input logic [7:0] k);
    int n;
    wr(1'b1, lhp_pkg::CMD_CURSOR_DIR);
    wr(1'b1, lhp_pkg::CMD_CURSOR_LOAD);
    wr(1'b0, 8'h00);
    wr(1'b0, 8'h48);
    wr(1'b1, lhp_pkg::CMD_MEMORY_WRITE);
    n = wcnt;
    for (int i = 0; i < 16; i++)
      wr(1'b0, k ^ 8'(i));
    repeat (10) @(posedge sys_clk);
    chk(16'(wcnt - n), 16'h10);
    for (int i = 0; i < 16; i++)
      chk({8'h0, mem[16'h4800 + 16'(i)]}, {8'h0, k ^ 8'(i)});
  endtask : t_write

  task automatic t_read(input logic [7:0] k);
    logic [7:0] q;
    wr(1'b1, lhp_pkg::CMD_CURSOR_LOAD);
    wr(1'b0, 8'h00);
    wr(1'b0, 8'h48);
    wr(1'b1, lhp_pkg::CMD_MEMORY_READ);
    for (int i = 0; i < 16; i++)
    begin
      host.access(1'b1, 1'b1, 8'h00, q);
      chk({8'h0, q}, {8'h0, k ^ 8'(i)});
    end
  endtask : t_read

  task automatic t_status();
    logic [7:0] q;
    logic       hi;
    logic       lo;
    hi = 1'b0;
    lo = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      host.access(1'b0, 1'b1, 8'h00, q);
      // The 22-cycle spacing walks the sample point across the whole line
      @(posedge sys_clk);
      if (q[6] === 1'b1)
        hi = 1'b1;
      if (q[6] === 1'b0)
        lo = 1'b1;
    end
    chk({15'h0, hi}, 16'h1);
    chk({15'h0, lo}, 16'h1);
  endtask : t_status

  task automatic t_sleep();
    int n;
    wr(1'b1, lhp_pkg::CMD_SLEEP_IN);
    chk({15'h0, slp}, 16'h1);
    n = wcnt;
    wr(1'b1, lhp_pkg::CMD_CURSOR_LOAD);
    wr(1'b0, 8'h00);
    wr(1'b0, 8'h50);
    wr(1'b1, lhp_pkg::CMD_MEMORY_WRITE);
    wr(1'b0, 8'h33);
    repeat (10) @(posedge sys_clk);
    chk(16'(wcnt - n), 16'h0);
    wr(1'b1, lhp_pkg::CMD_SYSTEM_SET);
    chk({15'h0, slp}, 16'h0);
  endtask : t_sleep

  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    n_errors   = 0;
    num_checks = 0;
    cyc        = 0;
    wcnt       = 0;
    last_we    = 0;
    rst_n      = 1'b0;
    style_e    = 1'b1;
    style_b    = 1'b1;
    rom_en     = 1'b1;
    fold       = 1'b0;
    tall       = 1'b0;
    code       = 8'h00;
    row        = 4'h0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({12'h0, m_we, m_re, d_oe, slp}, 16'h0);
    t_glyph();
    t_write(8'h70);
    t_read(8'h70);
    @(posedge sys_clk);
    style_b <= 1'b0;
    @(posedge sys_clk);
    host.idle();
    repeat (10) @(posedge sys_clk);
    t_write(8'hc9);
    t_read(8'hc9);
    t_status();
    t_sleep();
    complete_run();
  end
endmodule : lcd_ctrl_host_port_cg_addressing_test
